//--- clock_distribution_pkg.sv
// Purpose: Shared constants and types for the clock distribution control block.
// Assumes: 200 MHz core clock; register port with 4-bit word addresses.
// Notes: Phase error windows are expressed in core clock cycles.
`default_nettype none
package clock_distribution_pkg;

  // ==========================================================
  // Register offsets
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_OUT0 = 4'h1;
  localparam logic [3:0] REG_CAL = 4'h5;
  localparam logic [3:0] REG_STATUS = 4'h6;
  localparam int NUM_OUT = 4;

  // ==========================================================
  // Field positions
  localparam int CTRL_GEN_BIT = 0;
  localparam int CTRL_PD_BIT = 1;
  localparam int CTRL_QR_BIT = 2;
  localparam int CTRL_LMUX_LSB = 4;
  localparam int CTRL_ODIV_LSB = 8;
  localparam int OUT_EN_BIT = 0;
  localparam int OUT_PATH_LSB = 1;
  localparam int OUT_DLY_LSB = 4;
  localparam int OUT_DIV_LSB = 8;
  localparam int CAL_W = 28;

  // ==========================================================
  // Values after reset
  localparam logic GEN_RST = 1'b1;
  localparam logic OUT_EN_RST = 1'b0;
  localparam logic [3:0] ODIV_RST = 4'h2;
  localparam logic [3:0] ODIV_MIN = 4'h2;
  localparam logic [7:0] OUT_DIV_RST = 8'h01;

  // ==========================================================
  // Timing
  localparam int DLY_STEP_PS = 150;
  localparam int DLY_MAX_PS = 2250;
  localparam logic [1:0] SYNC_WAIT = 2'h3;
  localparam logic [2:0] LOCK_COUNT = 3'h5;
  localparam logic [1:0] QR_LAST = 2'h3;
  localparam int CLK_PERIOD_PS = 5000;
  localparam int ENTRY_WIN_PS = 10000;
  localparam int EXIT_WIN_PS = 20000;
  // Windows are longest times, so round down
  localparam logic [7:0] ENTRY_WIN_CYC = 8'(ENTRY_WIN_PS / CLK_PERIOD_PS);
  localparam logic [7:0] EXIT_WIN_CYC = 8'(EXIT_WIN_PS / CLK_PERIOD_PS);

  // ==========================================================
  // Types
  typedef enum logic [1:0] {
    PATH_BYPASS = 2'b00,
    PATH_DIV = 2'b01,
    PATH_DLY = 2'b10,
    PATH_DIV_DLY = 2'b11
  } path_e;

  typedef enum logic [1:0] {
    SY_RUN = 2'b00,
    SY_ENTER = 2'b01,
    SY_HOLD = 2'b10,
    SY_LEAVE = 2'b11
  } sync_e;

  typedef enum logic [1:0] {
    LM_LOW = 2'b00,
    LM_DLD_HI = 2'b01,
    LM_DLD_LO = 2'b10,
    LM_HIGH = 2'b11
  } lmux_e;

  typedef enum logic [1:0] {
    OS_OFF = 2'b00,
    OS_LOW = 2'b01,
    OS_RUN = 2'b10
  } ostate_e;

  typedef struct packed {
    logic en;
    path_e path;
    logic [3:0] dly;
    logic [7:0] div;
  } out_cfg_s;

  typedef struct packed {
    logic gen;
    logic pd;
    logic qr;
    lmux_e lmux;
    logic [3:0] odiv;
  } ctrl_s;

endpackage : clock_distribution_pkg
`default_nettype wire

//--- clock_distribution_control.sv
// Purpose: Digital control of a four-output clock distribution path.
// Assumes: Core clock stands in for the oscillator; the distribution clock
//   is core_clk divided by the oscillator divider value, with values below 2 taken as 2.
// Notes: Analog delay line is steered by delay_code, 150 ps per step.
// Notes on behaviour
// R01 - Each output delay programmable in 150 ps steps, 0 to 2250 ps.
// R02 - Outputs disabled singly by enable bit, all by global pin or bit.
// R03 - Off if enable or global bit zero; low if pin low; else running.
// R04 - Divided or even divider: 50% duty; odd bypass: 33, 40, 43%.
// R05 - Sync pin low holds divided outputs low; bypassed outputs keep running.
// R06 - After sync high, divided outputs rise together, aligned with bypassed.
// R07 - Driver holds sync low longer than one distribution clock period.
// R08 - Outputs go low, and later rise, on fifth distribution edge.
// R09 - Sync completes even if released before outputs went low.
// R10 - Sync input defaults high; outputs run when left unconnected.
// R11 - Global enable pin defaults high; then bits alone decide.
// R12 - Lock pin wired to global pin forces outputs low when unlocked.
// R13 - Power-on reset loads every configuration register with default.
// R14 - Lock declared after 5 consecutive cycles of error below 10 ns.
// R15 - Once locked, window widens to 20 ns for loss of lock.
// R16 - Lock pin shows detector only in digital lock modes, either polarity.
// R17 - In power-down, lock pin shows the not-locked level.
// R18 - Quarter-rate bit divides lock detector comparison rate by 4.
// R19 - Every calibration register write starts calibration, even same value.
// R20 - System supplies valid reference when calibration register written.
// R21 - Before lock, an error at or above window clears the counter.
//
// The implementer's own choices: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

module clock_distribution_control #(
  parameter int ADDR_W = 4
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [31:0] wdata,
  input wire logic we,
  input wire logic re,
  output logic [31:0] rdata,
  input wire logic sync_n_pin,
  input wire logic global_enable_pin,
  input wire logic pd_sample,
  input wire logic [7:0] pd_err,
  output logic [3:0] clk_out,
  output logic [7:0] out_state,
  output logic [15:0] delay_code,
  output logic lock_pin,
  output logic cal_start
);

  // ==========================================================
  // State
  typedef struct packed {
    clock_distribution_pkg::ctrl_s ctrl;
    clock_distribution_pkg::out_cfg_s [3:0] oc;
    logic [clock_distribution_pkg::CAL_W-1:0] cal_val;
    logic sync_m;
    logic sync_s;
    logic enpin_m;
    logic enpin_s;
    logic [3:0] ph;
    clock_distribution_pkg::sync_e sy;
    logic [1:0] sy_cnt;
    logic [3:0][7:0] dcnt;
    logic [3:0] dclk;
    logic [1:0] qr_cnt;
    logic [2:0] lk_cnt;
    logic locked;
    logic [3:0] clk_out;
    clock_distribution_pkg::ostate_e [3:0] os;
    logic [3:0][3:0] dly_code;
    logic lock_pin;
    logic cal_start;
    logic [31:0] rdata;
  } st_s;

  st_s st_ff;
  st_s nxt_st;

  // ==========================================================
  // Next state
  always_comb
  begin
    logic [3:0] odv;
    logic dtick;
    logic byp;
    logic hold;
    logic restart;
    logic smp;
    logic lvl;
    logic [7:0] ddiv;
    odv = st_ff.ctrl.odiv;
    dtick = 1'b0;
    byp = 1'b0;
    hold = 1'b0;
    restart = 1'b0;
    smp = 1'b0;
    lvl = 1'b0;
    ddiv = 8'h00;
    nxt_st = st_ff;
    nxt_st.cal_start = 1'b0;
    nxt_st.rdata = 32'h0000_0000;

    // Pins pass two flops before use; reset value 1 mimics the pull-ups
    // R10 sync default high
    nxt_st.sync_m = sync_n_pin;
    nxt_st.sync_s = st_ff.sync_m;
    // R11 enable default high
    nxt_st.enpin_m = global_enable_pin;
    nxt_st.enpin_s = st_ff.enpin_m;

    // ========================================================
    // Register writes
    if (we)
    begin
      if (addr == ADDR_W'(clock_distribution_pkg::REG_CTRL))
      begin
        nxt_st.ctrl.gen = wdata[clock_distribution_pkg::CTRL_GEN_BIT];
        nxt_st.ctrl.pd = wdata[clock_distribution_pkg::CTRL_PD_BIT];
        nxt_st.ctrl.qr = wdata[clock_distribution_pkg::CTRL_QR_BIT];
        nxt_st.ctrl.lmux = clock_distribution_pkg::lmux_e'(
          wdata[clock_distribution_pkg::CTRL_LMUX_LSB +: 2]);
        nxt_st.ctrl.odiv = wdata[clock_distribution_pkg::CTRL_ODIV_LSB +: 4];
      end
      // R19 any write calibrates
      if (addr == ADDR_W'(clock_distribution_pkg::REG_CAL))
      begin
        nxt_st.cal_val = wdata[clock_distribution_pkg::CAL_W-1:0];
        nxt_st.cal_start = 1'b1;
      end
      for (int i = 0; i < clock_distribution_pkg::NUM_OUT; i++)
      begin
        if (addr == ADDR_W'(clock_distribution_pkg::REG_OUT0 + 4'(i)))
        begin
          nxt_st.oc[i].en = wdata[clock_distribution_pkg::OUT_EN_BIT];
          nxt_st.oc[i].path = clock_distribution_pkg::path_e'(
            wdata[clock_distribution_pkg::OUT_PATH_LSB +: 2]);
          nxt_st.oc[i].dly = wdata[clock_distribution_pkg::OUT_DLY_LSB +: 4];
          nxt_st.oc[i].div = wdata[clock_distribution_pkg::OUT_DIV_LSB +: 8];
        end
      end
    end

    // ========================================================
    // Register reads; unmapped addresses read zero
    if (re)
    begin
      if (addr == ADDR_W'(clock_distribution_pkg::REG_CTRL))
      begin
        nxt_st.rdata[clock_distribution_pkg::CTRL_GEN_BIT] = st_ff.ctrl.gen;
        nxt_st.rdata[clock_distribution_pkg::CTRL_PD_BIT] = st_ff.ctrl.pd;
        nxt_st.rdata[clock_distribution_pkg::CTRL_QR_BIT] = st_ff.ctrl.qr;
        nxt_st.rdata[clock_distribution_pkg::CTRL_LMUX_LSB +: 2] = st_ff.ctrl.lmux;
        nxt_st.rdata[clock_distribution_pkg::CTRL_ODIV_LSB +: 4] = st_ff.ctrl.odiv;
      end
      if (addr == ADDR_W'(clock_distribution_pkg::REG_CAL))
      begin
        nxt_st.rdata[clock_distribution_pkg::CAL_W-1:0] = st_ff.cal_val;
      end
      if (addr == ADDR_W'(clock_distribution_pkg::REG_STATUS))
      begin
        nxt_st.rdata[0] = st_ff.locked;
        nxt_st.rdata[2:1] = st_ff.sy;
        nxt_st.rdata[3] = st_ff.sync_s;
        nxt_st.rdata[4] = st_ff.enpin_s;
        nxt_st.rdata[15:8] = st_ff.os;
        nxt_st.rdata[19:16] = st_ff.clk_out;
      end
      for (int i = 0; i < clock_distribution_pkg::NUM_OUT; i++)
      begin
        if (addr == ADDR_W'(clock_distribution_pkg::REG_OUT0 + 4'(i)))
        begin
          nxt_st.rdata[clock_distribution_pkg::OUT_EN_BIT] = st_ff.oc[i].en;
          nxt_st.rdata[clock_distribution_pkg::OUT_PATH_LSB +: 2] = st_ff.oc[i].path;
          nxt_st.rdata[clock_distribution_pkg::OUT_DLY_LSB +: 4] = st_ff.oc[i].dly;
          nxt_st.rdata[clock_distribution_pkg::OUT_DIV_LSB +: 8] = st_ff.oc[i].div;
        end
      end
    end

    // ========================================================
    // Distribution clock from the oscillator divider
    if (odv < clock_distribution_pkg::ODIV_MIN)
    begin
      odv = clock_distribution_pkg::ODIV_MIN;
    end
    dtick = (st_ff.ph == 4'h0);
    nxt_st.ph = (st_ff.ph >= odv - 4'h1) ? 4'h0 : st_ff.ph + 4'h1;
    // R04 bypass duty floor(n/2)/n
    byp = (st_ff.ph < (odv >> 1));

    // ========================================================
    // Sync sequencer, advanced on distribution edges only
    hold = (st_ff.sy == clock_distribution_pkg::SY_HOLD) ||
           (st_ff.sy == clock_distribution_pkg::SY_LEAVE);
    if (dtick)
    begin
      unique case (st_ff.sy)
        clock_distribution_pkg::SY_RUN:
        begin
          // R07 low must span an edge
          if (!st_ff.sync_s)
          begin
            nxt_st.sy = clock_distribution_pkg::SY_ENTER;
            nxt_st.sy_cnt = 2'h0;
          end
        end
        clock_distribution_pkg::SY_ENTER:
        begin
          // R09 finishes despite early release
          // R08 low on fifth edge
          if (st_ff.sy_cnt == clock_distribution_pkg::SYNC_WAIT)
          begin
            nxt_st.sy = clock_distribution_pkg::SY_HOLD;
            hold = 1'b1;
          end
          else
          begin
            nxt_st.sy_cnt = st_ff.sy_cnt + 2'h1;
          end
        end
        clock_distribution_pkg::SY_HOLD:
        begin
          if (st_ff.sync_s)
          begin
            nxt_st.sy = clock_distribution_pkg::SY_LEAVE;
            nxt_st.sy_cnt = 2'h0;
          end
        end
        clock_distribution_pkg::SY_LEAVE:
        begin
          // R08 rise on fifth edge
          if (st_ff.sy_cnt == clock_distribution_pkg::SYNC_WAIT)
          begin
            nxt_st.sy = clock_distribution_pkg::SY_RUN;
            restart = 1'b1;
          end
          else
          begin
            nxt_st.sy_cnt = st_ff.sy_cnt + 2'h1;
          end
        end
      endcase
    end

    // ========================================================
    // Per-output divider, gating and delay
    for (int i = 0; i < clock_distribution_pkg::NUM_OUT; i++)
    begin
      ddiv = (st_ff.oc[i].div == 8'h00) ? 8'h01 : st_ff.oc[i].div;
      // R06 restart all together
      if (restart)
      begin
        nxt_st.dclk[i] = 1'b1;
        nxt_st.dcnt[i] = 8'h00;
      end
      // R05 hold divided low
      else if (hold)
      begin
        nxt_st.dclk[i] = 1'b0;
        nxt_st.dcnt[i] = 8'h00;
      end
      // R04 divided toggles, 50% duty
      else if (dtick)
      begin
        if (st_ff.dcnt[i] >= ddiv - 8'h01)
        begin
          nxt_st.dcnt[i] = 8'h00;
          nxt_st.dclk[i] = ~st_ff.dclk[i];
        end
        else
        begin
          nxt_st.dcnt[i] = st_ff.dcnt[i] + 8'h01;
        end
      end
      // R05 bypass ignores sync
      lvl = (st_ff.oc[i].path == clock_distribution_pkg::PATH_DIV ||
             st_ff.oc[i].path == clock_distribution_pkg::PATH_DIV_DLY) ?
            nxt_st.dclk[i] : byp;
      // R02 single and global disable
      // R03 off, low or running
      if (!st_ff.oc[i].en || !st_ff.ctrl.gen || st_ff.ctrl.pd)
      begin
        nxt_st.os[i] = clock_distribution_pkg::OS_OFF;
        nxt_st.clk_out[i] = 1'b0;
      end
      // R12 unlock via pin forces low
      else if (!st_ff.enpin_s)
      begin
        nxt_st.os[i] = clock_distribution_pkg::OS_LOW;
        nxt_st.clk_out[i] = 1'b0;
      end
      else
      begin
        nxt_st.os[i] = clock_distribution_pkg::OS_RUN;
        nxt_st.clk_out[i] = lvl;
      end
      // R01 full 4-bit code spans 0 to 2250 ps
      nxt_st.dly_code[i] = st_ff.oc[i].dly;
    end

    // ========================================================
    // Digital lock detector
    if (pd_sample)
    begin
      nxt_st.qr_cnt = st_ff.qr_cnt + 2'h1;
    end
    // R18 quarter-rate comparison
    smp = pd_sample && (!st_ff.ctrl.qr || st_ff.qr_cnt == clock_distribution_pkg::QR_LAST);
    if (st_ff.ctrl.pd)
    begin
      nxt_st.locked = 1'b0;
      nxt_st.lk_cnt = 3'h0;
    end
    else if (smp)
    begin
      if (!st_ff.locked)
      begin
        // R14 five good cycles
        if (pd_err < clock_distribution_pkg::ENTRY_WIN_CYC)
        begin
          if (st_ff.lk_cnt == clock_distribution_pkg::LOCK_COUNT - 3'h1)
          begin
            nxt_st.locked = 1'b1;
            nxt_st.lk_cnt = 3'h0;
          end
          else
          begin
            nxt_st.lk_cnt = st_ff.lk_cnt + 3'h1;
          end
        end
        // R21 bad cycle clears count
        else
        begin
          nxt_st.lk_cnt = 3'h0;
        end
      end
      // R15 wider exit window
      else if (pd_err > clock_distribution_pkg::EXIT_WIN_CYC)
      begin
        nxt_st.locked = 1'b0;
      end
    end

    // R16 pin mux and polarity
    // R17 power-down shows unlocked
    unique case (st_ff.ctrl.lmux)
      clock_distribution_pkg::LM_LOW: nxt_st.lock_pin = 1'b0;
      clock_distribution_pkg::LM_DLD_HI: nxt_st.lock_pin = nxt_st.locked;
      clock_distribution_pkg::LM_DLD_LO: nxt_st.lock_pin = ~nxt_st.locked;
      clock_distribution_pkg::LM_HIGH: nxt_st.lock_pin = 1'b1;
    endcase
  end

  // ==========================================================
  // State register
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      // R13 defaults on reset
      st_ff <= '0;
      st_ff.ctrl.gen <= clock_distribution_pkg::GEN_RST;
      st_ff.ctrl.odiv <= clock_distribution_pkg::ODIV_RST;
      st_ff.sync_m <= 1'b1;
      st_ff.sync_s <= 1'b1;
      st_ff.enpin_m <= 1'b1;
      st_ff.enpin_s <= 1'b1;
      for (int i = 0; i < clock_distribution_pkg::NUM_OUT; i++)
      begin
        st_ff.oc[i].en <= clock_distribution_pkg::OUT_EN_RST;
        st_ff.oc[i].div <= clock_distribution_pkg::OUT_DIV_RST;
      end
    end
    else if (ce)
    begin
      st_ff <= nxt_st;
    end
  end

  assign rdata = st_ff.rdata;
  assign clk_out = st_ff.clk_out;
  assign out_state = st_ff.os;
  assign delay_code = st_ff.dly_code;
  assign lock_pin = st_ff.lock_pin;
  assign cal_start = st_ff.cal_start;

endmodule : clock_distribution_control

`default_nettype wire

//--- clock_distribution_assertions.sv
// Purpose: Port-level checks for the clock distribution control block.
// Assumes: ce held high; a single clock domain.
// Notes: Bound to every instance of the block.
`timescale 1ns/1ps
`default_nettype none

module clock_distribution_assertions #(
  parameter int ADDR_W = 4
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic we,
  input wire logic re,
  input wire logic [31:0] rdata,
  input wire logic global_enable_pin,
  input wire logic pd_sample,
  input wire logic [3:0] clk_out,
  input wire logic [7:0] out_state,
  input wire logic [15:0] delay_code,
  input wire logic lock_pin,
  input wire logic cal_start
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  // ==========================================================
  // Properties
  cal_after_write_a:
    assert property (we && addr == clock_distribution_pkg::REG_CAL |=> cal_start)
    else $error("calibration start missing after write");
  cal_cause_a:
    assert property (cal_start |-> $past(we) && $past(addr) == clock_distribution_pkg::REG_CAL)
    else $error("calibration start without write");
  rdata_idle_a:
    assert property (!$past(re) |-> rdata == 32'h0000_0000)
    else $error("read data not zero outside read answer");
  reset_dflt_a:
    assert property ($rose(nrst) |-> out_state == 8'h00 && clk_out == 4'h0 &&
      delay_code == 16'h0000 && !lock_pin)
    else $error("outputs not at reset values");
  lock_rise_a:
    assert property ($rose(lock_pin) |-> $past(pd_sample) || $past(we) || $past(we, 2))
    else $error("lock pin rose without cause");
  lock_fall_a:
    assert property ($fell(lock_pin) |-> $past(pd_sample) || $past(we) || $past(we, 2))
    else $error("lock pin fell without cause");
  dly_cause_a:
    assert property ($changed(delay_code) |-> $past(we) || $past(we, 2))
    else $error("delay code moved without write");
  gpin_low_a:
    assert property (!global_enable_pin [*4] |=> ((out_state >> 1) & ~out_state & 8'h55) == 0)
    else $error("output running while enable pin low");
endmodule : clock_distribution_assertions

bind clock_distribution_control clock_distribution_assertions #(.ADDR_W(ADDR_W)) chk_i (
  .core_clk(core_clk), .nrst(nrst), .addr(addr), .we(we), .re(re), .rdata(rdata),
  .global_enable_pin(global_enable_pin), .pd_sample(pd_sample), .clk_out(clk_out),
  .out_state(out_state), .delay_code(delay_code), .lock_pin(lock_pin), .cal_start(cal_start));
`default_nettype wire

//--- ref_phase_source.sv
// Purpose: Phase detector stand-in giving one phase error every four cycles.
// Assumes: Shares the core clock with the block.
// Notes: Error bus flips every cycle outside a sample, so stale data never looks valid.
`timescale 1ns/1ps
`default_nettype none

module ref_phase_source (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [7:0] err_in,
  output logic pd_sample,
  output logic [7:0] pd_err
);
  logic [1:0] cnt_ff;

  // ==========================================================
  // Reference cycle pulses
  // reference always valid
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      cnt_ff <= 2'h0;
      pd_sample <= 1'b0;
      pd_err <= 8'h00;
    end
    else
    begin
      cnt_ff <= cnt_ff + 2'h1;
      pd_sample <= (cnt_ff == 2'h3);
      pd_err <= (cnt_ff == 2'h3) ? err_in : ~pd_err;
    end
  end
endmodule : ref_phase_source
`default_nettype wire

//--- tb.sv
// Purpose: Self-checking bench for the clock distribution control block.
// Assumes: Register port answers reads one cycle later; ce held high.
// Notes: Phase errors come from ref_phase_source, four cycles apart.
`timescale 1ns/1ps
`default_nettype none

module tb;
  logic core_clk;
  logic nrst = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic we = 1'b0;
  logic re = 1'b0;
  logic sync_n_pin = 1'b1;
  logic global_enable_pin = 1'b1;
  logic [7:0] perr = 8'hff;
  logic [31:0] rdata;
  logic pd_sample, lock_pin, cal_start;
  logic [7:0] pd_err, out_state;
  logic [3:0] clk_out;
  logic [15:0] delay_code;
  logic [3:0] divs [4] = '{4'h3, 4'h4, 4'h5, 4'h7};
  int n_errors = 0;
  int checked = 0;
  int ncal = 0;
  int hi;

  clock_distribution_control #(.ADDR_W(4)) clock_distribution_control_i (
    .core_clk(core_clk), .nrst(nrst), .ce(1'b1), .addr(addr), .wdata(wdata), .we(we),
    .re(re), .rdata(rdata), .sync_n_pin(sync_n_pin), .global_enable_pin(global_enable_pin),
    .pd_sample(pd_sample), .pd_err(pd_err), .clk_out(clk_out), .out_state(out_state),
    .delay_code(delay_code), .lock_pin(lock_pin), .cal_start(cal_start));
  ref_phase_source ref_phase_source_i (.core_clk(core_clk), .nrst(nrst), .err_in(perr),
    .pd_sample(pd_sample), .pd_err(pd_err));

  initial
  begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  always @(posedge core_clk)
  begin
    if (cal_start === 1'b1)
      ncal <= ncal + 1;
  end

  // ==========================================================
  // Tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : cyc

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk);
    addr <= a;
    wdata <= d;
    we <= 1'b1;
    @(posedge core_clk);
    we <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
    @(posedge core_clk);
    addr <= a;
    re <= 1'b1;
    @(posedge core_clk);
    re <= 1'b0;
    #1;
    chk(rdata & m, e);
  endtask : rd

  // Counts n phase samples with the given error, then lets lock settle
  task automatic lk(input int n, input logic [7:0] err);
    #1 perr = err;
    repeat (n)
    begin
      do
      begin
        @(posedge core_clk);
        #1;
      end
      while (pd_sample !== 1'b1);
    end
    cyc(2);
  endtask : lk

  // Low streak of six marks the hold; bypass output must keep toggling meanwhile
  task automatic sync_pulse(input int len);
    int z;
    int tog;
    int rise;
    logic b;
    z = 0;
    tog = 0;
    rise = 0;
    b = clk_out[0];
    for (int i = 0; i < len + 60; i++)
    begin
      @(posedge core_clk);
      sync_n_pin <= (i >= len);
      #1;
      if (z >= 4 && clk_out[0] !== b)
        tog++;
      b = clk_out[0];
      if (clk_out[2:1] === 2'b00)
        z++;
      else
      begin
        if (z >= 6 && rise == 0)
        begin
          rise = i;
          chk(32'(clk_out[2:1]), 32'h3);
        end
        z = 0;
      end
    end
    chk(32'(rise >= len + 8 && rise <= len + 30), 32'h1);
    chk(32'(tog > 0), 32'h1);
  endtask : sync_pulse

  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : final_report

  initial
  begin
    #50us;
    n_errors++;
    final_report();
  end

  // ==========================================================
  // Sequence
  initial
  begin
    repeat (2) @(posedge core_clk);
    nrst <= 1'b1;
    rd(4'h0, 32'hffff_ffff, 32'h0000_0201);
    rd(4'h1, 32'hffff_ffff, 32'h0000_0100);
    wr(4'h7, 32'hffff_ffff);
    rd(4'h7, 32'hffff_ffff, 32'h0);
    wr(4'h5, 32'h0abc_def1);
    wr(4'h5, 32'h0abc_def1);
    cyc(2);
    chk(32'(ncal), 32'h2);
    rd(4'h5, 32'hffff_ffff, 32'h0abc_def1);
    wr(4'h1, 32'h0000_01f1);
    wr(4'h2, 32'h0000_0103);
    wr(4'h3, 32'h0000_0273);
    wr(4'h4, 32'h0000_0005);
    cyc(4);
    chk(32'(delay_code), 32'h0000_070f);
    chk(32'(out_state), 32'h0000_00aa);
    @(posedge core_clk);
    global_enable_pin <= 1'b0;
    cyc(5);
    chk(32'(out_state), 32'h0000_0055);
    wr(4'h0, 32'h0000_0200);
    cyc(3);
    chk(32'(out_state), 32'h0);
    @(posedge core_clk);
    global_enable_pin <= 1'b1;
    foreach (divs[k])
    begin
      wr(4'h0, {20'h0, divs[k], 8'h01});
      cyc(10);
      hi = 0;
      repeat (6 * divs[k])
      begin
        @(posedge core_clk);
        #1;
        hi += 32'(clk_out[0]) + 32'(clk_out[3]);
      end
      chk(32'(hi), 32'(12 * (divs[k] / 2)));
    end
    wr(4'h0, 32'h0000_0201);
    cyc(10);
    sync_pulse(20);
    // low spans more than one distribution period
    sync_pulse(3);
    wr(4'h0, 32'h0000_0211);
    lk(4, 8'h01);
    lk(1, 8'h02);
    lk(4, 8'h01);
    chk(32'(lock_pin), 32'h0);
    lk(1, 8'h01);
    chk(32'(lock_pin), 32'h1);
    lk(3, 8'h04);
    chk(32'(lock_pin), 32'h1);
    lk(1, 8'h05);
    chk(32'(lock_pin), 32'h0);
    lk(5, 8'h00);
    wr(4'h0, 32'h0000_0221);
    cyc(3);
    chk(32'(lock_pin), 32'h0);
    wr(4'h0, 32'h0000_0223);
    cyc(3);
    chk(32'(lock_pin), 32'h1);
    wr(4'h0, 32'h0000_0215);
    lk(15, 8'h00);
    chk(32'(lock_pin), 32'h0);
    lk(8, 8'h00);
    chk(32'(lock_pin), 32'h1);
    rd(4'h6, 32'h0000_0001, 32'h0000_0001);
    wr(4'h0, 32'h0000_0205);
    cyc(3);
    chk(32'(lock_pin), 32'h0);
    wr(4'h0, 32'h0000_0237);
    cyc(3);
    chk(32'(lock_pin), 32'h1);
    final_report();
  end
endmodule : tb
`default_nettype wire
